// ===== hw/pmr_pkg.sv
package pmr_pkg;

   // bus address bytes; bit 0 selects the direction
   localparam logic [7:0] ADDR_WRITE       = 8'hee;
   localparam logic [7:0] ADDR_READ        = 8'hef;

   // register offsets
   localparam logic [7:0] CALIB_FIRST      = 8'haa;
   localparam logic [7:0] CALIB_LAST       = 8'hbf;
   localparam logic [7:0] CMD_OFFSET       = 8'hf4;
   localparam logic [7:0] RES_HIGH_OFFSET  = 8'hf6;
   localparam logic [7:0] RES_LOW_OFFSET   = 8'hf7;
   localparam logic [7:0] RES_EXT_OFFSET   = 8'hf8;
   localparam int         CALIB_COUNT      = 22;

   // command values
   localparam logic [7:0] CMD_TEMP         = 8'h2e;
   localparam logic [7:0] CMD_PRESS_OSS0   = 8'h34;
   localparam logic [7:0] CMD_PRESS_OSS1   = 8'h74;
   localparam logic [7:0] CMD_PRESS_OSS2   = 8'hb4;
   localparam logic [7:0] CMD_PRESS_OSS3   = 8'hf4;

   // command register fields
   localparam int         CTRL_ACTIVE_BIT  = 5;
   localparam int         CTRL_OSS_MSB     = 7;
   localparam int         CTRL_OSS_LSB     = 6;

   // values after reset
   localparam logic [7:0] CMD_RESET        = 8'h00;
   localparam logic [7:0] RES_HIGH_RESET   = 8'h80;
   localparam logic [7:0] RES_LOW_RESET    = 8'h00;
   localparam logic [7:0] RES_EXT_RESET    = 8'h00;

   // conversion times and the cycle counts derived from them (rounded down)
   localparam real        CLK_PERIOD_NS    = 4.0;
   localparam real        TIME_TEMP_MS     = 4.5;
   localparam real        TIME_OSS0_MS     = 4.5;
   localparam real        TIME_OSS1_MS     = 7.5;
   localparam real        TIME_OSS2_MS     = 13.5;
   localparam real        TIME_OSS3_MS     = 25.5;
   localparam int unsigned CYC_TEMP        = $rtoi(TIME_TEMP_MS * 1.0e6 / CLK_PERIOD_NS);
   localparam int unsigned CYC_OSS0        = $rtoi(TIME_OSS0_MS * 1.0e6 / CLK_PERIOD_NS);
   localparam int unsigned CYC_OSS1        = $rtoi(TIME_OSS1_MS * 1.0e6 / CLK_PERIOD_NS);
   localparam int unsigned CYC_OSS2        = $rtoi(TIME_OSS2_MS * 1.0e6 / CLK_PERIOD_NS);
   localparam int unsigned CYC_OSS3        = $rtoi(TIME_OSS3_MS * 1.0e6 / CLK_PERIOD_NS);
   // cycles kept back so that the result bytes land before the deadline
   localparam int unsigned FIN_MARGIN      = 8;

   // result fifo: {byte select, byte}
   localparam int         FIFO_WIDTH       = 10;
   localparam int         FIFO_DEPTH       = 8;
   localparam logic [1:0] SEL_HIGH         = 2'h0;
   localparam logic [1:0] SEL_LOW          = 2'h1;
   localparam logic [1:0] SEL_EXT          = 2'h2;

   typedef enum logic [2:0] {
      st_idle,
      st_addr,
      st_reg,
      st_wdata,
      st_ack,
      st_tx,
      st_hack
   } pmr_i2c_state_type;

endpackage : pmr_pkg

// ===== hw/pmr_fifo.sv
`timescale 1ns/1ps
module pmr_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 8
) (
   input  wire logic             i_clk,     // system clock
   input  wire logic             i_resetn,  // synchronous reset, active low
   input  wire logic             i_valid,   // write side data valid
   input  wire logic [WIDTH-1:0] i_data,    // write side data
   output logic                  o_ready,   // room for one more word
   output logic                  o_valid,   // read side data valid
   output logic [WIDTH-1:0]      o_data,    // head word
   input  wire logic             i_ready    // read side takes the head word
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 n;
   } pmr_fifo_state_type;

   pmr_fifo_state_type r;
   pmr_fifo_state_type next_r;
   logic               push;
   logic               pop;

   assign o_ready = (r.n != (AW+1)'(DEPTH));
   assign o_valid = (r.n != '0);
   assign o_data  = r.mem[r.rp];
   assign push    = i_valid && o_ready;
   assign pop     = o_valid && i_ready;

   always_comb
   begin
      next_r = r;
      if (push)
      begin
         next_r.mem[r.wp] = i_data;
         next_r.wp        = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + AW'(1);
      end
      if (pop)
      begin
         next_r.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + AW'(1);
      end
      next_r.n = r.n + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
         r <= '0;
      else
         r <= next_r;
   end

endmodule : pmr_fifo

// ===== hw/pmr_conv.sv
`timescale 1ns/1ps
module pmr_conv
   import pmr_pkg::*;
#(
   parameter int unsigned P_CYC_TEMP = CYC_TEMP,
   parameter int unsigned P_CYC_OSS0 = CYC_OSS0,
   parameter int unsigned P_CYC_OSS1 = CYC_OSS1,
   parameter int unsigned P_CYC_OSS2 = CYC_OSS2,
   parameter int unsigned P_CYC_OSS3 = CYC_OSS3
) (
   input  wire logic        i_clk,                   // system clock
   input  wire logic        i_resetn,                // synchronous reset, active low
   input  wire logic        i_start,                 // one-cycle start pulse
   input  wire logic        i_is_press,              // 1 pressure, 0 temperature
   input  wire logic [1:0]  i_oss,                   // oversampling code
   input  wire logic [15:0] i_raw_temperature_word,  // raw temperature from front end
   input  wire logic [18:0] i_raw_pressure,          // raw pressure from front end
   output logic             o_valid,                 // result byte valid
   output logic [9:0]       o_data,                  // {select, byte}
   input  wire logic        i_ready                  // fifo room
);
   typedef struct packed {
      logic        busy;
      logic        is_press;
      logic [1:0]  oss;
      logic [23:0] cnt;
      logic [23:0] age;
      logic        push;
      logic [1:0]  idx;
      logic [23:0] data;
   } pmr_conv_state_type;

   pmr_conv_state_type r;
   pmr_conv_state_type next_r;
   logic [23:0]        press24;

   function automatic logic [23:0] conv_cycles(input logic p, input logic [1:0] o);
      logic [23:0] c;
      c = 24'(P_CYC_TEMP);
      if (p)
      begin
         case (o)
            2'h0:    c = 24'(P_CYC_OSS0);
            2'h1:    c = 24'(P_CYC_OSS1);
            2'h2:    c = 24'(P_CYC_OSS2);
            default: c = 24'(P_CYC_OSS3);
         endcase
      end
      return c;
   endfunction : conv_cycles

   // keep 16+oss top bits of the pressure; lower bits read zero
   assign press24 = {i_raw_pressure, 5'h00} & ~(24'hffffff >> (5'h10 + 5'(r.oss)));

   always_comb
   begin
      next_r = r;
      if (i_start)
      begin
         // a new command restarts the conversion
         next_r.busy     = 1'b1;
         next_r.is_press = i_is_press;
         next_r.oss      = i_oss;
         next_r.cnt      = conv_cycles(i_is_press, i_oss) - 24'(FIN_MARGIN);
         next_r.age      = '0;
         next_r.push     = 1'b0;
      end
      else if (r.busy)
      begin
         next_r.age = r.age + 24'h000001;
         if (r.cnt <= 24'h000001)
         begin
            next_r.busy = 1'b0;
            next_r.push = 1'b1;
            next_r.idx  = SEL_HIGH;
            next_r.data = r.is_press ? press24 : {i_raw_temperature_word, 8'h00};
         end
         else
            next_r.cnt = r.cnt - 24'h000001;
      end
      else if (r.push && i_ready)
      begin
         if (r.idx == SEL_EXT)
            next_r.push = 1'b0;
         else
            next_r.idx = r.idx + 2'h1;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
         r <= '0;
      else
         r <= next_r;
   end

   assign o_valid = r.push;
   assign o_data  = {r.idx, (r.idx == SEL_HIGH) ? r.data[23:16] : (r.idx == SEL_LOW) ? r.data[15:8] : r.data[7:0]};

   a_conv_within_max: assert property (@(posedge i_clk) disable iff (!i_resetn)
      r.busy |-> r.age < conv_cycles(r.is_press, r.oss))
      else $error("conversion runs past its maximum time");

   a_ext_byte_width: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (r.push && r.idx == SEL_EXT) |-> (r.is_press ? (r.data[2:0] == 3'h0) : (r.data[7:0] == 8'h00)))
      else $error("extension byte carries bits beyond the result width");

endmodule : pmr_conv

// ===== hw/pmr_readout.sv
`timescale 1ns/1ps
module pmr_readout
   import pmr_pkg::*;
#(
   parameter int unsigned P_CYC_TEMP = CYC_TEMP,
   parameter int unsigned P_CYC_OSS0 = CYC_OSS0,
   parameter int unsigned P_CYC_OSS1 = CYC_OSS1,
   parameter int unsigned P_CYC_OSS2 = CYC_OSS2,
   parameter int unsigned P_CYC_OSS3 = CYC_OSS3
) (
   input  wire logic                     i_clk,                   // system clock, 250 MHz
   input  wire logic                     i_resetn,                // synchronous reset, active low
   input  wire logic                     i_scl,                   // serial clock pin level
   input  wire logic                     i_sda,                   // serial data pin level
   output logic                          o_sda_out,               // serial data drive value, always low
   output logic                          o_sda_oe,                // high while pulling serial data low
   output logic                          o_conversion_active,     // copy of the active bit
   input  wire logic [15:0]              i_raw_temperature_word,  // front end temperature sample
   input  wire logic [18:0]              i_raw_pressure,          // front end pressure sample
   input  wire logic [CALIB_COUNT*8-1:0] i_calibration            // calibration bytes, byte 0 first
);
   typedef struct packed {
      logic [2:0]        scl_s;
      logic [2:0]        sda_s;
      pmr_i2c_state_type st;
      pmr_i2c_state_type after;
      logic [3:0]        cnt;
      logic [7:0]        sh;
      logic [7:0]        ptr;
      logic              oe;
      logic [7:0]        ctrl;
      logic [7:0]        res_high;
      logic [7:0]        res_low;
      logic [7:0]        res_ext;
      logic              start;
      logic              is_press;
   } pmr_readout_state_type;

   pmr_readout_state_type r;
   pmr_readout_state_type next_r;

   logic [7:0]            cal [0:CALIB_COUNT-1];
   logic [7:0]            rd_byte;
   logic                  scl_rise;
   logic                  scl_fall;
   logic                  bus_start;
   logic                  bus_stop;
   logic                  quiet;
   logic                  byte_done;
   logic                  cmd_wr;
   logic                  cmd_valid;
   logic                  drain_ok;
   logic                  conv_valid;
   logic [9:0]            conv_data;
   logic                  conv_ready;
   logic                  fifo_valid;
   logic [9:0]            fifo_data;
   logic                  fifo_pop;

   genvar g;
   generate
      for (g = 0; g < CALIB_COUNT; g++)
      begin : g_cal
         assign cal[g] = i_calibration[g*8 +: 8];
      end
   endgenerate

   // bus events from the second and third synchroniser stages only
   assign scl_rise  = r.scl_s[1] && !r.scl_s[2];
   assign scl_fall  = !r.scl_s[1] && r.scl_s[2];
   assign bus_start = r.scl_s[1] && r.scl_s[2] && r.sda_s[2] && !r.sda_s[1];
   assign bus_stop  = r.scl_s[1] && r.scl_s[2] && !r.sda_s[2] && r.sda_s[1];
   assign quiet     = !bus_start && !bus_stop;
   assign byte_done = quiet && scl_fall && (r.cnt == 4'h8);
   assign cmd_wr    = byte_done && (r.st == st_wdata) && (r.ptr == CMD_OFFSET);
   assign cmd_valid = (r.sh == CMD_TEMP) || (r.sh == CMD_PRESS_OSS0) || (r.sh == CMD_PRESS_OSS1)
                      || (r.sh == CMD_PRESS_OSS2) || (r.sh == CMD_PRESS_OSS3);

   // results are not updated under a read in flight, so a burst stays coherent
   assign drain_ok  = (r.st == st_idle) || (r.st == st_addr) || (r.st == st_reg) || (r.st == st_wdata);
   assign fifo_pop  = fifo_valid && drain_ok;

   always_comb
   begin
      rd_byte = 8'h00;
      if (r.ptr >= CALIB_FIRST && r.ptr <= CALIB_LAST)
         rd_byte = cal[5'(r.ptr - CALIB_FIRST)];
      else
      begin
         case (r.ptr)
            CMD_OFFSET:      rd_byte = r.ctrl;
            RES_HIGH_OFFSET: rd_byte = r.res_high;
            RES_LOW_OFFSET:  rd_byte = r.res_low;
            RES_EXT_OFFSET:  rd_byte = r.res_ext;
            default:         rd_byte = 8'h00;
         endcase
      end
   end

   always_comb
   begin
      next_r        = r;
      next_r.start  = 1'b0;
      next_r.scl_s  = {r.scl_s[1:0], i_scl};
      next_r.sda_s  = {r.sda_s[1:0], i_sda};

      if (fifo_pop)
      begin
         case (fifo_data[9:8])
            SEL_HIGH: next_r.res_high = fifo_data[7:0];
            SEL_LOW:  next_r.res_low  = fifo_data[7:0];
            default:
            begin
               next_r.res_ext                 = fifo_data[7:0];
               next_r.ctrl[CTRL_ACTIVE_BIT]   = 1'b0;
            end
         endcase
      end

      if (bus_stop)
      begin
         next_r.st = st_idle;
         next_r.oe = 1'b0;
      end
      else if (bus_start)
      begin
         // a repeated start lands here too; the pointer is kept
         next_r.st  = st_addr;
         next_r.cnt = 4'h0;
         next_r.oe  = 1'b0;
      end
      else if (scl_rise)
      begin
         case (r.st)
            st_addr, st_reg, st_wdata:
            begin
               if (r.cnt != 4'h8)
               begin
                  next_r.sh  = {r.sh[6:0], r.sda_s[1]};
                  next_r.cnt = r.cnt + 4'h1;
               end
            end
            st_hack:
            begin
               if (r.sda_s[1])
                  next_r.st = st_idle;
               else
               begin
                  next_r.st    = st_ack;
                  next_r.after = st_tx;
               end
            end
            default: ;
         endcase
      end
      else if (scl_fall)
      begin
         case (r.st)
            st_addr:
            begin
               if (r.cnt == 4'h8)
               begin
                  if (r.sh[7:1] == ADDR_WRITE[7:1])
                  begin
                     next_r.oe    = 1'b1;
                     next_r.st    = st_ack;
                     next_r.after = (r.sh == ADDR_READ) ? st_tx : st_reg;
                  end
                  else
                     next_r.st = st_idle;
               end
            end
            st_reg:
            begin
               if (r.cnt == 4'h8)
               begin
                  next_r.ptr   = r.sh;
                  next_r.oe    = 1'b1;
                  next_r.st    = st_ack;
                  next_r.after = st_wdata;
               end
            end
            st_wdata:
            begin
               if (r.cnt == 4'h8)
               begin
                  if (r.ptr == CMD_OFFSET)
                  begin
                     // the set after a drain clear in the same cycle wins
                     next_r.ctrl = {r.sh[CTRL_OSS_MSB:CTRL_OSS_LSB], cmd_valid, r.sh[4:0]};
                     next_r.start    = cmd_valid;
                     next_r.is_press = (r.sh != CMD_TEMP);
                  end
                  next_r.ptr   = r.ptr + 8'h01;
                  next_r.oe    = 1'b1;
                  next_r.st    = st_ack;
                  next_r.after = st_wdata;
               end
            end
            st_ack:
            begin
               next_r.oe  = 1'b0;
               next_r.cnt = 4'h0;
               if (r.after == st_tx)
               begin
                  next_r.sh  = rd_byte;
                  next_r.oe  = !rd_byte[7];
                  next_r.cnt = 4'h1;
                  next_r.st  = st_tx;
               end
               else
                  next_r.st = r.after;
            end
            st_tx:
            begin
               if (r.cnt == 4'h8)
               begin
                  next_r.oe  = 1'b0;
                  next_r.st  = st_hack;
                  next_r.ptr = r.ptr + 8'h01;
               end
               else
               begin
                  next_r.sh  = {r.sh[6:0], 1'b0};
                  next_r.oe  = !r.sh[6];
                  next_r.cnt = r.cnt + 4'h1;
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         r          <= '0;
         r.scl_s    <= 3'h7;
         r.sda_s    <= 3'h7;
         r.st       <= st_idle;
         r.after    <= st_idle;
         r.ctrl     <= CMD_RESET;
         r.res_high <= RES_HIGH_RESET;
         r.res_low  <= RES_LOW_RESET;
         r.res_ext  <= RES_EXT_RESET;
      end
      else
         r <= next_r;
   end

   assign o_sda_out           = 1'b0;
   assign o_sda_oe            = r.oe;
   assign o_conversion_active = r.ctrl[CTRL_ACTIVE_BIT];

   pmr_conv #(
      .P_CYC_TEMP (P_CYC_TEMP),
      .P_CYC_OSS0 (P_CYC_OSS0),
      .P_CYC_OSS1 (P_CYC_OSS1),
      .P_CYC_OSS2 (P_CYC_OSS2),
      .P_CYC_OSS3 (P_CYC_OSS3)
   ) u_conv (
      .i_clk                  (i_clk),
      .i_resetn               (i_resetn),
      .i_start                (r.start),
      .i_is_press             (r.is_press),
      .i_oss                  (r.ctrl[CTRL_OSS_MSB:CTRL_OSS_LSB]),
      .i_raw_temperature_word (i_raw_temperature_word),
      .i_raw_pressure         (i_raw_pressure),
      .o_valid                (conv_valid),
      .o_data                 (conv_data),
      .i_ready                (conv_ready)
   );
   pmr_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_valid  (conv_valid),
      .i_data   (conv_data),
      .o_ready  (conv_ready),
      .o_valid  (fifo_valid),
      .o_data   (fifo_data),
      .i_ready  (drain_ok)
   );

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   sequence s_addr_match;
      byte_done && r.st == st_addr && r.sh[7:1] == ADDR_WRITE[7:1];
   endsequence
   sequence s_last_result;
      fifo_pop && fifo_data[9:8] == SEL_EXT;
   endsequence
   sequence s_tx_load;
      quiet && scl_fall && r.st == st_ack && r.after == st_tx;
   endsequence
   a_temp_cmd_start: assert property (cmd_wr && r.sh == CMD_TEMP |=> r.start && !r.is_press)
      else $error("temperature command did not start a conversion");
   a_press_cmd_start: assert property (
      cmd_wr && r.sh[5:0] == CMD_PRESS_OSS0[5:0]
      |=> r.start && r.is_press && r.ctrl[CTRL_OSS_MSB:CTRL_OSS_LSB] == $past(r.sh[7:6]))
      else $error("pressure command did not start with its oversampling");
   a_active_set: assert property (cmd_wr && cmd_valid |=> r.ctrl[CTRL_ACTIVE_BIT] ##1 r.ctrl[CTRL_ACTIVE_BIT])
      else $error("active bit not held after a command");
   a_active_clear: assert property (s_last_result ##0 !cmd_wr |=> !r.ctrl[CTRL_ACTIVE_BIT])
      else $error("active bit not cleared when results filled");
   a_addr_ack: assert property (s_addr_match |=> r.oe && r.st == st_ack)
      else $error("own address byte not acknowledged");
   a_write_ack: assert property (byte_done && r.st == st_wdata |=> r.oe ##0 r.st == st_ack)
      else $error("written byte not acknowledged");
   a_tx_msb_first: assert property (s_tx_load |=> r.oe == !$past(rd_byte[7]) && r.sh == $past(rd_byte))
      else $error("transmit did not start with the top bit");
   a_ptr_advance: assert property (byte_done && r.st == st_tx |=> r.ptr == $past(r.ptr) + 8'h01)
      else $error("pointer did not advance after a sent byte");
   a_result_high: assert property (fifo_pop && fifo_data[9:8] == SEL_HIGH |=> r.res_high == $past(fifo_data[7:0]))
      else $error("high result byte not stored");

endmodule : pmr_readout

// ===== test/pmr_host_model.sv
`timescale 1ns/1ps
module pmr_host_model (
   input  wire logic i_clk,     // system clock
   input  wire logic i_sda,     // resolved data wire
   output logic      o_scl,     // serial clock, idle high
   output logic      o_sda_low  // pulls data low
);
   initial
   begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   task automatic ph(input logic c, input logic l, input int n);
      o_scl <= c;
      o_sda_low <= l;
      repeat (n) @(posedge i_clk);
   endtask : ph
   // data flips while the clock is high, giving a start (a=0) or a stop (a=1); bitx moves data only mid-low
   task automatic cond(input logic a);
      ph(1'b0, o_sda_low, 4);
      ph(1'b0, a, 4);
      ph(1'b1, a, 8);
      ph(1'b1, ~a, 8);
   endtask : cond
   task automatic bitx(input logic b, output logic s);
      ph(1'b0, o_sda_low, 4);
      ph(1'b0, ~b, 4);
      ph(1'b1, ~b, 4);
      @(negedge i_clk) s = i_sda;
      repeat (4) @(posedge i_clk);
   endtask : bitx
   task automatic wbyte(input logic [7:0] v, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bitx(v[i], s);
      bitx(1'b1, s);
      ack = ~s;
   endtask : wbyte
   task automatic rbyte(input logic ack, output logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bitx(1'b1, s);
         v[i] = s;
      end
      bitx(~ack, s);
   endtask : rbyte
endmodule : pmr_host_model

// ===== test/pmr_readout_tb_top.sv
`timescale 1ns/1ps
module pmr_readout_tb_top
   import pmr_pkg::*;
;
   localparam int unsigned LIM [5] = '{200, 200, 300, 500, 900};
   logic       clk = 1'b0, resetn = 1'b0, a, oe, sdo, act, scl, sda_low;
   logic [15:0] tw = '0;
   logic [18:0] pw = '0;
   logic [175:0] cal;
   logic [7:0] cmd [5] = '{CMD_TEMP, CMD_PRESS_OSS0, CMD_PRESS_OSS1, CMD_PRESS_OSS2, CMD_PRESS_OSS3};
   logic [7:0] d, got [$];
   logic [23:0] e;
   int         n_fail = 0, checks_done = 0, seed = 95, n;
   wire        sda = ~(sda_low | (oe & ~sdo));
   always #2 clk = ~clk;
   pmr_readout #(.P_CYC_TEMP(LIM[0]), .P_CYC_OSS0(LIM[1]), .P_CYC_OSS1(LIM[2]), .P_CYC_OSS2(LIM[3]),
      .P_CYC_OSS3(LIM[4])) DUT (.i_clk(clk), .i_resetn(resetn), .i_scl(scl), .i_sda(sda), .o_sda_out(sdo),
      .o_sda_oe(oe), .o_conversion_active(act), .i_raw_temperature_word(tw), .i_raw_pressure(pw),
      .i_calibration(cal));
   pmr_host_model H (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
   task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // calibration is a plain input, so it is re-drawn mid-run to keep it from looking tied
   task automatic fill_cal;
      logic [CALIB_COUNT*8-1:0] v;
      for (int i = 0; i < CALIB_COUNT; i++) v[8*i +: 8] = $random(seed);
      cal <= v;
   endtask : fill_cal
   task automatic addr(input logic [7:0] r);
      H.cond(1'b0);
      H.wbyte(ADDR_WRITE, a);
      chk("write address ack", a, 1);
      H.wbyte(r, a);
      chk("register ack", a, 1);
   endtask : addr
   task automatic rd(input logic [7:0] r, input int k);
      addr(r);
      H.cond(1'b0);
      H.wbyte(ADDR_READ, a);
      chk("read address ack", a, 1);
      got.delete();
      for (int i = 0; i < k; i++)
      begin
         H.rbyte(i < k - 1, d);
         got.push_back(d);
      end
      H.cond(1'b1);
   endtask : rd
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test
   initial
   begin
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      fill_cal;
      repeat (4) @(posedge clk);
      chk("active after reset", act, 0);
      rd(RES_HIGH_OFFSET, 3);
      chk("reset result", {got[0], got[1], got[2]},
          {RES_HIGH_RESET, RES_LOW_RESET, RES_EXT_RESET});
      H.cond(1'b0);
      H.wbyte(8'hec, a);
      chk("foreign address ack", a, 0);
      H.cond(1'b1);
      for (int k = 0; k < 5; k++)
      begin
         tw <= $random(seed);
         pw <= $random(seed);
         addr(CMD_OFFSET);
         H.wbyte(cmd[k], a);
         chk("command ack", a, 1);
         H.cond(1'b1);
         chk("active while converting", act, 1);
         n = 0;
         while (act === 1'b1 && n < 2000)
         begin
            @(posedge clk);
            n++;
         end
         chk("conversion time", n <= LIM[k], 1);
         e = k == 0 ? {tw, 8'h00} : {pw, 5'h00} & (24'hffffff << (9 - k));
         rd(RES_HIGH_OFFSET, 3);
         chk("result", {got[0], got[1], got[2]}, e);
      end
      // last command was the top oversampling; its active bit must have dropped
      rd(CMD_OFFSET, 1);
      chk("command register", got[0], {CMD_PRESS_OSS3[7:6], 1'b0, CMD_PRESS_OSS3[4:0]});
      fill_cal;
      rd(CALIB_FIRST, 2);
      chk("first calibration", {got[0], got[1]}, {cal[7:0], cal[15:8]});
      rd(CALIB_LAST, 1);
      chk("last calibration", got[0], cal[175 -: 8]);
      end_of_test;
   end
   initial
   begin
      repeat (60000) @(posedge clk);
      n_fail++;
      end_of_test;
   end
endmodule : pmr_readout_tb_top
